// >>> quad_uart_host_status_regs.vh
`ifndef QUAD_UART_HOST_STATUS_REGS_VH
`define QUAD_UART_HOST_STATUS_REGS_VH
`define NUM_CHANNELS      4
`define ADDR_WIDTH        5
`define DATA_WIDTH        8
`define CHAN_SEL_MSB      4
`define CHAN_SEL_LSB      3
`define REG_SEL_WIDTH     3
`define MCR_OFFSET        3'h4
`define MCR_INFRARED_BIT  6
`define MCR_RESET_VALUE   8'h00
`define BUS_MODE_68       1'b0
`define BUS_MODE_16       1'b1
`endif

// >>> quad_uart_host_status_pins.v
// Operation
// - 68 mode merges four channel interrupts
// - Shared interrupt low for enabled pending sources
// - 68 mode interrupt pulls low or releases
// - 16 mode: pin becomes channel A interrupt
// - Per-channel infrared transmit output, framed characters
// - Infrared output zero in reset, idle, disabled
// - Control bit 6 selects modem or infrared
// - Music clock lets serial pins act music ports
// - 16 mode: reset high resets everything
// - Serial transmit and receive disabled during reset
// - 68 mode: reset input active low
// - Strobe falling edge writes selected channel's control register only
// - Strobe rising edge drives register onto bus
// - Combined receive ready low when any data
// - Combined receive ready high when none remain
// - Channel receive ready low while data unread and trigger level reached
// - Combined transmit ready low if any space
// - Largest variant has combined and channel outputs
// - Channel transmit ready low while space remains
`timescale 1ns/1ps
`default_nettype none
`include "quad_uart_host_status_regs.vh"
module quad_uart_host_status_pins
(
   // Clock and reset pin
   input  wire                         clk,
   input  wire                         reset,
   // Bus mode: 1 selects 16 mode, 0 selects 68 mode
   input  wire                         busMode16,
   // Host bus, 68 mode strobe
   input  wire                         chipSelect_n,
   input  wire                         readWrite_n,
   input  wire [`ADDR_WIDTH-1:0]       register_address_lines,
   input  wire [`DATA_WIDTH-1:0]       hostDataIn,
   output reg  [`DATA_WIDTH-1:0]       hostDataOut,
   output reg                          hostDataOe_n,
   // Per-channel state from the UART cores
   input  wire [`NUM_CHANNELS-1:0]     channelIrqPending,
   input  wire [`NUM_CHANNELS-1:0]     rxDataAvailable,
   input  wire [`NUM_CHANNELS-1:0]     rxTriggerReached,
   input  wire [`NUM_CHANNELS-1:0]     txSpaceAvailable,
   input  wire [`NUM_CHANNELS-1:0]     txSerialData,
   input  wire [`NUM_CHANNELS-1:0]     txActive,
   input  wire [`NUM_CHANNELS-1:0]     txEnabled,
   input  wire [`NUM_CHANNELS*`DATA_WIDTH-1:0] channelReadData,
   // Music link clock and serial pins
   input  wire                         music_link_clock_in,
   input  wire                         musicClockPresent,
   input  wire [`NUM_CHANNELS-1:0]     serialRxPin,
   input  wire [`NUM_CHANNELS-1:0]     musicTxData,
   output reg  [`NUM_CHANNELS-1:0]     serial_transmit_port,
   output reg  [`NUM_CHANNELS-1:0]     serial_receive_port,
   output reg  [`NUM_CHANNELS-1:0]     musicPortMode,
   // Shared interrupt, open drain in 68 mode
   output reg                          sharedIrqOut,
   output reg                          sharedIrqOe_n,
   output reg                          channel_a_interrupt,
   // Ready outputs
   output reg                          combined_rx_ready_n,
   output reg                          combined_tx_ready_n,
   output reg  [`NUM_CHANNELS-1:0]     channel_rx_ready_n,
   output reg  [`NUM_CHANNELS-1:0]     channel_tx_ready_n,
   // Infrared outputs and per-channel mode control
   output reg  [`NUM_CHANNELS-1:0]     infrared_tx_out,
   output reg  [`NUM_CHANNELS*`DATA_WIDTH-1:0] modem_control_register
);

   // Reset polarity follows the bus mode
   wire                         resetActive;
   wire                         mode68;

   // Strobe edge detection and address split
   reg                          strobePrev;
   wire                         strobeFall;
   wire                         strobeRise;
   wire [1:0]                   chanSel;
   wire [`REG_SEL_WIDTH-1:0]    regSel;
   wire                         writeHit;
   wire                         readHit;

   // Combinational OR terms, registered below
   wire                         anyIrq;
   wire                         anyRx;
   wire                         anyTx;

   // Next values of the shared outputs
   reg                          next_sharedIrqOe_n;
   reg                          next_channelAIrq;
   reg                          next_combinedRx_n;
   reg                          next_combinedTx_n;
   reg  [`DATA_WIDTH-1:0]       next_hostDataOut;
   reg                          next_hostDataOe_n;

   // Register select decode, shared by the write and read paths
   function isControlReg;
      input [`REG_SEL_WIDTH-1:0] sel;
      begin
         isControlReg = (sel == `MCR_OFFSET);
      end
   endfunction

   // One channel's byte out of a per-channel vector
   function [`DATA_WIDTH-1:0] channelByte;
      input [`NUM_CHANNELS*`DATA_WIDTH-1:0] vec;
      input [1:0]                           sel;
      begin
         channelByte = vec[sel*`DATA_WIDTH +: `DATA_WIDTH];
      end
   endfunction

   assign resetActive = (busMode16 == `BUS_MODE_16) ? reset : ~reset;
   assign mode68      = (busMode16 == `BUS_MODE_68);
   assign strobeFall  = strobePrev & ~readWrite_n;
   assign strobeRise  = ~strobePrev & readWrite_n;
   assign chanSel     = register_address_lines[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
   assign regSel      = register_address_lines[`REG_SEL_WIDTH-1:0];
   // Strobes are ignored in 16 mode and while deselected
   assign writeHit    = mode68 & strobeFall & ~chipSelect_n
                        & isControlReg(regSel);
   assign readHit     = mode68 & strobeRise & ~chipSelect_n;
   assign anyIrq      = |channelIrqPending;
   assign anyRx       = |rxDataAvailable;
   assign anyTx       = |txSpaceAvailable;

   // Idle strobe level is high, so reset must not fake an edge
   always @(posedge clk)
   begin
      if (resetActive)
      begin
         strobePrev <= 1'b1;
      end
      else
      begin
         strobePrev <= readWrite_n;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < `NUM_CHANNELS; ch = ch + 1)
      begin : chan
         wire                     infraredMode;
         wire                     chanWrite;
         reg  [`DATA_WIDTH-1:0]   next_mcr;
         reg                      next_infrared;
         reg                      next_serialTx;
         reg                      next_serialRx;
         reg                      next_musicMode;
         reg                      next_chanRx_n;
         reg                      next_chanTx_n;

         assign infraredMode = modem_control_register[ch*`DATA_WIDTH+`MCR_INFRARED_BIT];
         assign chanWrite    = writeHit & (chanSel == ch);

         // Only the control register lives here; others belong to the cores
         always @*
         begin
            next_mcr = modem_control_register[ch*`DATA_WIDTH +: `DATA_WIDTH];
            if (chanWrite)
            begin
               next_mcr = hostDataIn;
            end
         end

         // Idle or disabled transmitter keeps infrared line quiet
         always @*
         begin
            next_infrared = infraredMode & txEnabled[ch] & txActive[ch]
                            & ~txSerialData[ch];
         end

         // Music port takes precedence over both line interfaces on serial_transmit_port only; infrared_tx_out is not gated by it
         always @*
         begin
            next_musicMode = musicClockPresent;
            if (musicClockPresent)
            begin
               next_serialTx = musicTxData[ch];
            end
            else if (infraredMode)
            begin
               next_serialTx = 1'b1;
            end
            else
            begin
               next_serialTx = txSerialData[ch] | ~txEnabled[ch];
            end
            next_serialRx = serialRxPin[ch];
         end

         // Trigger level gates the per-channel receive flag
         always @*
         begin
            next_chanRx_n = ~(rxDataAvailable[ch] & rxTriggerReached[ch]);
            next_chanTx_n = ~txSpaceAvailable[ch];
         end

         always @(posedge clk)
         begin
            if (resetActive)
            begin
               modem_control_register[ch*`DATA_WIDTH +: `DATA_WIDTH] <= `MCR_RESET_VALUE;
               infrared_tx_out[ch]      <= 1'b0;
               serial_transmit_port[ch] <= 1'b1;
               serial_receive_port[ch]  <= 1'b1;
               musicPortMode[ch]        <= 1'b0;
               channel_rx_ready_n[ch]   <= 1'b1;
               channel_tx_ready_n[ch]   <= 1'b1;
            end
            else
            begin
               modem_control_register[ch*`DATA_WIDTH +: `DATA_WIDTH] <= next_mcr;
               infrared_tx_out[ch]      <= next_infrared;
               serial_transmit_port[ch] <= next_serialTx;
               serial_receive_port[ch]  <= next_serialRx;
               musicPortMode[ch]        <= next_musicMode;
               channel_rx_ready_n[ch]   <= next_chanRx_n;
               channel_tx_ready_n[ch]   <= next_chanTx_n;
            end
         end
      end
   endgenerate

   // Interrupt pin role depends on the bus mode
   always @*
   begin
      next_sharedIrqOe_n = 1'b1;
      next_channelAIrq   = 1'b0;
      if (mode68)
      begin
         // Open drain: external pull-up returns the pin high
         next_sharedIrqOe_n = ~anyIrq;
      end
      else
      begin
         next_channelAIrq = channelIrqPending[0];
      end
   end

   always @*
   begin
      next_combinedRx_n = ~anyRx;
      next_combinedTx_n = ~anyTx;
   end

   // Read data stands until the strobe falls or the chip is deselected
   always @*
   begin
      next_hostDataOut  = hostDataOut;
      next_hostDataOe_n = hostDataOe_n;
      if (readHit)
      begin
         next_hostDataOe_n = 1'b0;
         if (isControlReg(regSel))
         begin
            next_hostDataOut = channelByte(modem_control_register, chanSel);
         end
         else
         begin
            next_hostDataOut = channelByte(channelReadData, chanSel);
         end
      end
      else if (chipSelect_n || !readWrite_n)
      begin
         next_hostDataOe_n = 1'b1;
      end
   end

   // Sharing the pin means it never drives high; only the enable moves
   always @(posedge clk)
   begin
      if (resetActive)
      begin
         sharedIrqOut        <= 1'b0;
         sharedIrqOe_n       <= 1'b1;
         channel_a_interrupt <= 1'b0;
      end
      else
      begin
         sharedIrqOut        <= 1'b0;
         sharedIrqOe_n       <= next_sharedIrqOe_n;
         channel_a_interrupt <= next_channelAIrq;
      end
   end

   // Registered so that a glitch on one core never reaches the pins
   always @(posedge clk)
   begin
      if (resetActive)
      begin
         combined_rx_ready_n <= 1'b1;
         combined_tx_ready_n <= 1'b1;
      end
      else
      begin
         combined_rx_ready_n <= next_combinedRx_n;
         combined_tx_ready_n <= next_combinedTx_n;
      end
   end

   always @(posedge clk)
   begin
      if (resetActive)
      begin
         hostDataOut  <= {`DATA_WIDTH{1'b0}};
         hostDataOe_n <= 1'b1;
      end
      else
      begin
         hostDataOut  <= next_hostDataOut;
         hostDataOe_n <= next_hostDataOe_n;
      end
   end

endmodule
`default_nettype wire

// >>> quad_uart_checker.sv
`timescale 1ns/1ps
`default_nettype none
module quad_uart_checker(
   input wire logic clk, reset, busMode16, chipSelect_n, readWrite_n, hostDataOe_n,
   input wire logic sharedIrqOut, sharedIrqOe_n, channel_a_interrupt,
   input wire logic combined_rx_ready_n, combined_tx_ready_n,
   input wire logic [3:0] channelIrqPending, rxDataAvailable, rxTriggerReached,
   input wire logic [3:0] txSpaceAvailable, txActive, txEnabled, infrared_tx_out,
   input wire logic [3:0] channel_rx_ready_n, channel_tx_ready_n
);
   // Reset polarity flips with the bus mode
   wire rst = busMode16 ? reset : !reset;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_irq_merged: assert property (1 |=> sharedIrqOe_n ==
      ($past(busMode16) || $past(channelIrqPending) == 4'h0)) else $error("irq");
   a_irq_release: assert property (!sharedIrqOut) else $error("irq level");
   a_irq_chan_a: assert property (1 |=> channel_a_interrupt ==
      ($past(busMode16) && $past(channelIrqPending[0]))) else $error("irq a");
   a_rx_any: assert property (1 |=> combined_rx_ready_n ==
      ($past(rxDataAvailable) == 4'h0)) else $error("rx");
   a_tx_any: assert property (1 |=> combined_tx_ready_n ==
      ($past(txSpaceAvailable) == 4'h0)) else $error("tx");
   a_chan_ready: assert property (1 |=> {channel_rx_ready_n, channel_tx_ready_n} ==
      ~$past({rxDataAvailable & rxTriggerReached, txSpaceAvailable})) else $error("chan");
   a_ir_quiet: assert property (1 |=>
      (infrared_tx_out & ~$past(txActive & txEnabled)) == 4'h0) else $error("ir");
   a_read_drive: assert property ($rose(readWrite_n) && !chipSelect_n && !busMode16
      |=> !hostDataOe_n) else $error("read");
   c_irq: cover property (!sharedIrqOe_n);
   c_read: cover property (!hostDataOe_n);
   c_ir: cover property (infrared_tx_out != 4'h0);
endmodule
bind quad_uart_host_status_pins quad_uart_checker u_chk(.*);
`default_nettype wire

// >>> host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model(
   input wire logic clk, hostDataOe_n,
   input wire logic [7:0] hostDataOut,
   output logic chipSelect_n = '1, readWrite_n = '1,
   output logic [4:0] register_address_lines = '0,
   output logic [7:0] hostDataIn = '0
);
   // Strobe low a cycle then high: write, then read back
   task xfer(logic cs_n, logic [4:0] a, logic [7:0] d, output logic [7:0] q);
      @(posedge clk) #1;
      {chipSelect_n, register_address_lines, hostDataIn, readWrite_n} = {cs_n, a, d, 1'b0};
      @(posedge clk) #1;
      readWrite_n = 1'b1;
      @(posedge clk) #1;
      q = hostDataOe_n === 1'b0 ? hostDataOut : 8'hXX;
      // Released bus shows the inverse, never a stale copy
      {chipSelect_n, hostDataIn} = {1'b1, ~d};
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = '0, reset = '0, busMode16 = '0, musicClockPresent = '0, music_link_clock_in = '0;
   logic [3:0] channelIrqPending = '0, rxDataAvailable = '0, rxTriggerReached = '0, txActive = '0;
   logic [3:0] txSpaceAvailable = '0, txSerialData = '0, txEnabled = '0, serialRxPin = '0;
   logic [3:0] musicTxData = '0;
   logic [31:0] channelReadData = '0;
   logic [7:0] q;
   int failures = 0, checks = 0;
   wire [7:0] hostDataOut, hostDataIn;
   wire [4:0] register_address_lines;
   wire [31:0] modem_control_register;
   wire [3:0] serial_transmit_port, serial_receive_port, musicPortMode, infrared_tx_out;
   wire [3:0] channel_rx_ready_n, channel_tx_ready_n;
   wire hostDataOe_n, chipSelect_n, readWrite_n, sharedIrqOut, sharedIrqOe_n, channel_a_interrupt;
   wire combined_rx_ready_n, combined_tx_ready_n;
   wire [9:0] rdy = {combined_rx_ready_n, combined_tx_ready_n, channel_rx_ready_n, channel_tx_ready_n};
   wire [1:0] irq = {sharedIrqOe_n, channel_a_interrupt};
   quad_uart_host_status_pins u_dut(.*);
   host_cpu_model u_host(.*);
   initial forever #25 clk = ~clk;
   task chk(string n, logic [31:0] e, g);
      checks++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Inputs held busy so only reset can explain quiet outputs
   task t_rst(logic m);
      @(posedge clk) #1;
      {busMode16, reset} = {m, m};
      {channelIrqPending, rxDataAvailable, rxTriggerReached, txSpaceAvailable, txActive} = '1;
      repeat (12) @(posedge clk);
      #1;
      chk("reset pins", 24'hFFE0FF, {rdy, irq, infrared_tx_out, serial_transmit_port, serial_receive_port});
      chk("reset mcr", 32'h0, modem_control_register);
      reset = ~m;
   endtask
   task t_sts;
      logic [3:0] v, t;
      for (int i = 0; i < 5; i++)
      begin
         v = i < 4 ? 4'h1 << i : 4'h0;
         t = i == 2 ? 4'h0 : v;
         @(posedge clk) #1;
         {channelIrqPending, rxDataAvailable, rxTriggerReached, txSpaceAvailable} = {v, v, t, v};
         @(posedge clk) #1;
         chk("irq", {busMode16 || v == 4'h0, busMode16 && v[0]}, irq);
         chk("ready", {v == 4'h0, v == 4'h0, ~(v & t), ~v}, rdy);
      end
   endtask
   task t_mcr;
      for (int c = 0; c < 4; c++)
      begin
         u_host.xfer(1'b0, {c[1:0], 3'h4}, 8'h40 | c[7:0], q);
         chk("read", 8'h40 | c[7:0], q);
         chk("mcr", 8'h40 | c[7:0], modem_control_register[8 * c +: 8]);
      end
      u_host.xfer(1'b1, 5'h04, 8'h00, q);
      channelReadData = 32'hC3B2A190;
      u_host.xfer(1'b0, 5'h10, 8'h00, q);
      chk("read data", 8'hB2, q);
      chk("refused", 32'h43424140, modem_control_register);
   endtask
   task t_pin;
      @(posedge clk) #1;
      {txActive, txEnabled, txSerialData, musicClockPresent, serialRxPin, musicTxData} =
         {12'h7B5, 5'h1A, 4'h6};
      @(posedge clk) #1;
      chk("ir", 4'h2, infrared_tx_out);
      chk("music tx", 4'h6, serial_transmit_port);
      chk("music", 8'hFA, {musicPortMode, serial_receive_port});
      u_host.xfer(1'b0, 5'h0C, 8'h00, q);
      chk("ir off", 4'h0, infrared_tx_out);
   endtask
   initial
   begin
      t_rst(1'b0);
      t_sts;
      t_mcr;
      t_pin;
      t_rst(1'b1);
      t_sts;
      test_done;
   end
   initial
   begin
      #100000;
      failures++;
      test_done;
   end
endmodule
`default_nettype wire
